// ==== ltmc_pkg.sv ====
// What this block does
// - Regulator enable high except in power-down and power-on reset.
// - Power-down: transmitter, regulator off, wake logic on.
// - Power-down wakes to ready on activity/select, or on wake if HAS_FAULT_PIN is 0.
// - Select held high: ready advances once supplies stable.
// - Activity needs bus low beyond debounce time.
// - Ready: regulator on, receiver on, transmitter off.
// - After power-on: ready while select low, operation high.
// - Transmit low at select rise: transmitter off.
// - Operation: all on; select fall to power-down.
// - Operation faults force transmitter off state.
// - External low on fault pin forces transmitter off.
// - Transmitter off: select fall powers down, else recovers.
// - Recovery also needs transmit input high.
// - Power-on reset samples select: ready or operation.
// - Over-temperature disables driver, recovers automatically.
// - Bus dominant while transmit low; receive follows bus.
// - Transmit low past 10ms: release, transmitter off.
// - Fault pin low on overheat or stuck-high bus.
// - Disabled transmitter sees internal transmit as one.
package ltmc_pkg;
    localparam int CLK_MHZ = 200;
    localparam int DOM_TIMEOUT_MS = 10;
    localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int FAULT_DELAY_US = 25;
    localparam int FAULT_DELAY_CYC = FAULT_DELAY_US * CLK_MHZ;
    localparam int DEBOUNCE_CYC = 64;
    localparam int SUPPLY_CYC = 128;
    localparam int CNT_W = 32;

    typedef enum logic [2:0] {
        MODE_POR,
        MODE_READY,
        MODE_OPERATION,
        MODE_POWER_DOWN,
        MODE_TX_OFF
    } ltmc_mode_t;

    // Pins sampled through the synchroniser
    typedef struct packed {
        logic tx_data;
        logic select;
        logic wake_n;
        logic fault_in;
        logic bus_line;
        logic over_temp;
    } ltmc_pins_t;
endpackage

// ==== ltmc_buf.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-entry skid buffer
module ltmc_buf #(
    parameter int WIDTH = 1
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// ==== ltmc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ltmc_top #(
    parameter int DEBOUNCE_CYC = ltmc_pkg::DEBOUNCE_CYC,
    parameter int SUPPLY_CYC = ltmc_pkg::SUPPLY_CYC,
    parameter int DOM_TIMEOUT_CYC = ltmc_pkg::DOM_TIMEOUT_CYC,
    parameter int FAULT_DELAY_CYC = ltmc_pkg::FAULT_DELAY_CYC,
    parameter bit HAS_FAULT_PIN = 1'b1
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic tx_data_i,
    input wire logic select_i,
    input wire logic wake_n_i,
    input wire logic fault_tx_enable_n_i,
    output logic fault_tx_enable_n_o,
    output logic fault_tx_enable_n_oe_o,
    input wire logic bus_line_i,
    output logic bus_line_o,
    output logic bus_line_oe_o,
    input wire logic over_temp_i,
    output logic rx_data_o,
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output logic regulator_enable_o,
    output logic receiver_on_o,
    output logic transmitter_on_o,
    output logic [2:0] mode_o
);
    localparam int CW = ltmc_pkg::CNT_W;

    ltmc_pkg::ltmc_pins_t raw;
    ltmc_pkg::ltmc_pins_t sync1;
    ltmc_pkg::ltmc_pins_t pin;
    ltmc_pkg::ltmc_pins_t pin_d;
    ltmc_pkg::ltmc_mode_t mode;
    ltmc_pkg::ltmc_mode_t next_mode;
    logic [CW-1:0] deb_cnt;
    logic [CW-1:0] sup_cnt;
    logic [CW-1:0] dom_cnt;
    logic [CW-1:0] flt_cnt;
    logic activity;
    logic supply_ok;
    logic dom_expired;
    logic contention;
    logic fault_any;
    logic select_rise;
    logic select_fall;
    logic wake_fall;
    logic tx_rise;
    logic tx_enabled;
    logic tx_int;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_data;
    logic rx_prev;
    // Marks when the synchroniser holds real pin values after reset
    logic [1:0] sync_fill;

    assign raw = '{tx_data: tx_data_i, select: select_i, wake_n: wake_n_i,
                   fault_in: fault_tx_enable_n_i, bus_line: bus_line_i,
                   over_temp: over_temp_i};

    // Two-stage synchroniser, then a history stage for edges
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1 <= '{tx_data: 1'b1, select: 1'b0, wake_n: 1'b1,
                       fault_in: 1'b1, bus_line: 1'b1, over_temp: 1'b0};
            pin <= '{tx_data: 1'b1, select: 1'b0, wake_n: 1'b1,
                     fault_in: 1'b1, bus_line: 1'b1, over_temp: 1'b0};
            pin_d <= '{tx_data: 1'b1, select: 1'b0, wake_n: 1'b1,
                       fault_in: 1'b1, bus_line: 1'b1, over_temp: 1'b0};
            sync_fill <= 2'h0;
        end else begin
            sync_fill <= {sync_fill[0], 1'b1};
            sync1 <= raw;
            pin <= sync1;
            pin_d <= pin;
        end
    end

    assign select_rise = pin.select && !pin_d.select;
    assign select_fall = !pin.select && pin_d.select;
    assign wake_fall = !pin.wake_n && pin_d.wake_n;
    assign tx_rise = pin.tx_data && !pin_d.tx_data;

    // Bus activity debounce
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            deb_cnt <= '0;
        end else if (pin.bus_line) begin
            deb_cnt <= '0;
        end else if (deb_cnt <= CW'(DEBOUNCE_CYC)) begin
            deb_cnt <= deb_cnt + CW'(1);
        end
    end
    assign activity = (deb_cnt > CW'(DEBOUNCE_CYC));

    // Supply-stable delay, restarted on leaving power-down or reset
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sup_cnt <= '0;
        end else if (mode == ltmc_pkg::MODE_POWER_DOWN) begin
            sup_cnt <= '0;
        end else if (sup_cnt < CW'(SUPPLY_CYC)) begin
            sup_cnt <= sup_cnt + CW'(1);
        end
    end
    assign supply_ok = (sup_cnt >= CW'(SUPPLY_CYC));

    // Dominant timeout: latched until next transmit rising edge
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dom_cnt <= '0;
            dom_expired <= 1'b0;
        end else begin
            if (pin.tx_data || mode != ltmc_pkg::MODE_OPERATION) begin
                dom_cnt <= '0;
            end else if (dom_cnt < CW'(DOM_TIMEOUT_CYC)) begin
                dom_cnt <= dom_cnt + CW'(1);
            end
            if (dom_cnt >= CW'(DOM_TIMEOUT_CYC) && !pin.tx_data) begin
                dom_expired <= 1'b1;
            end else if (tx_rise) begin
                dom_expired <= 1'b0;
            end
        end
    end

    // Stuck-recessive bus check after transmit falls
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flt_cnt <= '0;
            contention <= 1'b0;
        end else begin
            if (pin.tx_data || !tx_enabled) begin
                flt_cnt <= '0;
            end else if (flt_cnt < CW'(FAULT_DELAY_CYC)) begin
                flt_cnt <= flt_cnt + CW'(1);
            end
            if (flt_cnt >= CW'(FAULT_DELAY_CYC) && !pin.tx_data
                && pin.bus_line) begin
                contention <= 1'b1;
            end else if (pin.tx_data) begin
                contention <= 1'b0;
            end
        end
    end

    assign fault_any = pin.over_temp || contention || dom_expired;

    always_comb begin
        next_mode = mode;
        case (mode)
            ltmc_pkg::MODE_POR: begin
                // Decide only once select has crossed the synchroniser
                if (sync_fill[1]) begin
                    if (pin.select)
                        next_mode = ltmc_pkg::MODE_OPERATION;
                    else
                        next_mode = ltmc_pkg::MODE_READY;
                end
            end
            ltmc_pkg::MODE_READY: begin
                if (pin.select && supply_ok) begin
                    if (!pin.tx_data)
                        next_mode = ltmc_pkg::MODE_TX_OFF;
                    else
                        next_mode = ltmc_pkg::MODE_OPERATION;
                end
            end
            ltmc_pkg::MODE_OPERATION: begin
                if (select_fall)
                    next_mode = ltmc_pkg::MODE_POWER_DOWN;
                else if (fault_any)
                    next_mode = ltmc_pkg::MODE_TX_OFF;
                else if (HAS_FAULT_PIN && !pin.fault_in && !fault_tx_enable_n_oe_o)
                    next_mode = ltmc_pkg::MODE_TX_OFF;
            end
            ltmc_pkg::MODE_TX_OFF: begin
                if (select_fall)
                    next_mode = ltmc_pkg::MODE_POWER_DOWN;
                else if (!fault_any && pin.tx_data && pin.select
                         && (!HAS_FAULT_PIN || pin.fault_in))
                    next_mode = ltmc_pkg::MODE_OPERATION;
            end
            ltmc_pkg::MODE_POWER_DOWN: begin
                if (activity || pin.select || (!HAS_FAULT_PIN && wake_fall))
                    next_mode = ltmc_pkg::MODE_READY;
            end
            default: next_mode = ltmc_pkg::MODE_POR;
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) mode <= ltmc_pkg::MODE_POR;
        else mode <= next_mode;
    end

    assign tx_enabled = (mode == ltmc_pkg::MODE_OPERATION) && !fault_any;
    assign tx_int = tx_enabled ? pin.tx_data : 1'b1;

    // Receive path through the buffer
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) rx_prev <= 1'b1;
        else if (buf_in_ready) rx_prev <= pin.bus_line;
    end

    ltmc_buf #(.WIDTH(1)) u_buf (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(pin.bus_line != rx_prev),
        .in_ready_o(buf_in_ready),
        .in_data_i(pin.bus_line),
        .out_valid_o(buf_out_valid),
        .out_ready_i(rx_ready_i),
        .out_data_o(buf_out_data)
    );

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_data_o <= 1'b1;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= buf_out_valid;
            if (buf_out_valid && rx_ready_i) rx_data_o <= buf_out_data;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_line_o <= 1'b0;
            bus_line_oe_o <= 1'b0;
        end else begin
            bus_line_o <= 1'b0;
            bus_line_oe_o <= !tx_int;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fault_tx_enable_n_o <= 1'b0;
            fault_tx_enable_n_oe_o <= 1'b0;
        end else begin
            fault_tx_enable_n_o <= 1'b0;
            fault_tx_enable_n_oe_o <= HAS_FAULT_PIN
                && (pin.over_temp || contention);
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            regulator_enable_o <= 1'b0;
            receiver_on_o <= 1'b0;
            transmitter_on_o <= 1'b0;
            mode_o <= 3'h0;
        end else begin
            regulator_enable_o <= next_mode != ltmc_pkg::MODE_POWER_DOWN
                && next_mode != ltmc_pkg::MODE_POR;
            receiver_on_o <= next_mode != ltmc_pkg::MODE_POR;
            transmitter_on_o <= next_mode == ltmc_pkg::MODE_OPERATION;
            mode_o <= next_mode;
        end
    end
endmodule
`default_nettype wire

// ==== ltmc_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module ltmc_top_properties (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic tx_data_i,
    input wire logic select_i,
    input wire logic over_temp_i,
    input wire logic fault_tx_enable_n_oe_o,
    input wire logic bus_line_oe_o,
    input wire logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic regulator_enable_o,
    input wire logic receiver_on_o,
    input wire logic transmitter_on_o,
    input wire logic [2:0] mode_o
);
    localparam logic [2:0] RDY = ltmc_pkg::MODE_READY;
    localparam logic [2:0] OPR = ltmc_pkg::MODE_OPERATION;
    localparam logic [2:0] PDN = ltmc_pkg::MODE_POWER_DOWN;
    localparam logic [2:0] TXO = ltmc_pkg::MODE_TX_OFF;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    a_vren_pd_off: assert property ((mode_o == PDN)[*2] |->
        !regulator_enable_o) else $error("regulator on in power-down");
    a_pd_tx_quiet: assert property ((mode_o == PDN)[*2] |->
        !transmitter_on_o && !bus_line_oe_o) else $error("driver on in pd");
    a_ready_rx_only: assert property ((mode_o == RDY)[*2] |->
        regulator_enable_o && receiver_on_o && !transmitter_on_o)
        else $error("ready outputs wrong");
    a_op_all_on: assert property ((mode_o == OPR)[*2] |->
        regulator_enable_o && receiver_on_o && transmitter_on_o)
        else $error("operation outputs wrong");
    a_select_fall_pd: assert property (mode_o == OPR && $fell(select_i)
        |-> ##[1:8] mode_o == PDN) else $error("no power-down");
    a_select_wakes: assert property (mode_o == PDN && $rose(select_i)
        |-> ##[1:8] mode_o != PDN) else $error("select did not wake");
    a_heat_tx_off: assert property (mode_o == OPR && $rose(over_temp_i)
        |-> ##[1:8] mode_o == TXO) else $error("overheat kept driver");
    a_heat_fault_flag: assert property ((mode_o == TXO && over_temp_i)[*6]
        |-> fault_tx_enable_n_oe_o) else $error("fault pin not pulled");
    a_tx_low_dominant: assert property ((mode_o == OPR && !tx_data_i)[*5]
        |-> bus_line_oe_o) else $error("bus not dominant");
    a_off_released: assert property ((!transmitter_on_o)[*3]
        |-> !bus_line_oe_o) else $error("disabled driver pulls bus");
    c_wake: cover property (mode_o == PDN ##1 mode_o == RDY);
    c_fault: cover property (mode_o == OPR ##1 mode_o == TXO);
    c_rx_pop: cover property (rx_valid_o && rx_ready_i);
endmodule
bind ltmc_top ltmc_top_properties ltmc_top_properties_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .tx_data_i(tx_data_i),
    .select_i(select_i), .over_temp_i(over_temp_i),
    .fault_tx_enable_n_oe_o(fault_tx_enable_n_oe_o),
    .bus_line_oe_o(bus_line_oe_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .regulator_enable_o(regulator_enable_o),
    .receiver_on_o(receiver_on_o), .transmitter_on_o(transmitter_on_o),
    .mode_o(mode_o));
`default_nettype wire

// ==== ltmc_lin_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module ltmc_lin_partner (
    input wire logic dev_bus_oe_i,
    input wire logic dev_fault_oe_i,
    input wire logic node_dominant_i,
    input wire logic short_high_i,
    input wire logic host_txe_low_i,
    output logic bus_line_o,
    output logic fault_pin_o
);
    // Pull-up unless someone pulls; a short to battery beats every driver
    assign bus_line_o = short_high_i | !(dev_bus_oe_i | node_dominant_i);
    // Open-drain pin with pull-up, shared by host and device
    assign fault_pin_o = !(dev_fault_oe_i | host_txe_low_i);
endmodule
`default_nettype wire

// ==== tb_lin_transceiver_mode_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module tb_lin_transceiver_mode_control;
    localparam logic [2:0] RDY = ltmc_pkg::MODE_READY;
    localparam logic [2:0] OPR = ltmc_pkg::MODE_OPERATION;
    localparam logic [2:0] PDN = ltmc_pkg::MODE_POWER_DOWN;
    localparam logic [2:0] TXO = ltmc_pkg::MODE_TX_OFF;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic tx = 1'b1, sel = 1'b0, wake_n = 1'b1, heat = 1'b0;
    logic node_dom = 1'b0, short_hi = 1'b0, txe_low = 1'b0, rx_rdy = 1'b1;
    wire logic bus, fpin, bus_oe, f_oe, rx_data, rx_valid, vren, tx_on;
    wire logic [2:0] mode;
    int bad_count = 0;
    int checks_done = 0;
    always #2.5 clock_i = ~clock_i;
    ltmc_top #(.DEBOUNCE_CYC(8), .SUPPLY_CYC(16), .DOM_TIMEOUT_CYC(50),
        .FAULT_DELAY_CYC(20), .HAS_FAULT_PIN(1'b1)) ltmc_top_i (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .tx_data_i(tx),
        .select_i(sel), .wake_n_i(wake_n), .fault_tx_enable_n_i(fpin),
        .fault_tx_enable_n_o(), .fault_tx_enable_n_oe_o(f_oe),
        .bus_line_i(bus), .bus_line_o(), .bus_line_oe_o(bus_oe),
        .over_temp_i(heat), .rx_data_o(rx_data), .rx_ready_i(rx_rdy),
        .rx_valid_o(rx_valid), .regulator_enable_o(vren),
        .receiver_on_o(), .transmitter_on_o(tx_on), .mode_o(mode));
    ltmc_lin_partner ltmc_lin_partner_i (.dev_bus_oe_i(bus_oe),
        .dev_fault_oe_i(f_oe), .node_dominant_i(node_dom),
        .short_high_i(short_hi), .host_txe_low_i(txe_low),
        .bus_line_o(bus), .fault_pin_o(fpin));
    task automatic step(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic wait_mode(input logic [2:0] m, input int n);
        for (int i = 0; i < n && mode !== m; i++) @(negedge clock_i);
        `CHK(mode, m)
    endtask
    task automatic do_reset(input logic s);
        reset_n_i = 1'b0;
        sel = s;
        step(10);
        `CHK(vren, 1'b0)
        reset_n_i = 1'b1;
    endtask
    task automatic t_power_on();
        do_reset(1'b0);
        wait_mode(RDY, 10);
        step(40);
        `CHK(mode, RDY)
        `CHK(tx_on, 1'b0)
        sel = 1'b1;
        wait_mode(OPR, 40);
    endtask
    task automatic t_data();
        tx = 1'b0;
        step(6);
        `CHK(bus, 1'b0)
        step(4);
        `CHK(rx_data, 1'b0)
        // Receiver stalls across two bus edges; neither may be lost
        rx_rdy = 1'b0;
        tx = 1'b1;
        step(8);
        tx = 1'b0;
        step(8);
        `CHK(rx_valid, 1'b1)
        tx = 1'b1;
        rx_rdy = 1'b1;
        step(10);
        `CHK(rx_valid, 1'b0)
        `CHK(rx_data, 1'b1)
    endtask
    task automatic t_timeout();
        tx = 1'b0;
        wait_mode(TXO, 80);
        step(2);
        `CHK(bus, 1'b1)
        tx = 1'b1;
        wait_mode(OPR, 20);
    endtask
    task automatic t_heat();
        heat = 1'b1;
        wait_mode(TXO, 10);
        step(6);
        `CHK(f_oe, 1'b1)
        // Host keeps transmit low while hot and reads receive back
        tx = 1'b0;
        step(4);
        `CHK(rx_data, 1'b1)
        heat = 1'b0;
        tx = 1'b1;
        wait_mode(OPR, 20);
    endtask
    task automatic t_txe();
        txe_low = 1'b1;
        wait_mode(TXO, 10);
        txe_low = 1'b0;
        wait_mode(OPR, 10);
    endtask
    task automatic t_contention();
        short_hi = 1'b1;
        tx = 1'b0;
        for (int i = 0; i < 40 && f_oe !== 1'b1; i++) step(1);
        `CHK(f_oe, 1'b1)
        wait_mode(TXO, 10);
        short_hi = 1'b0;
        tx = 1'b1;
        wait_mode(OPR, 40);
    endtask
    task automatic t_pd();
        sel = 1'b0;
        wait_mode(PDN, 10);
        step(2);
        `CHK(vren, 1'b0)
        `CHK(tx_on, 1'b0)
        node_dom = 1'b1;
        step(4);
        node_dom = 1'b0;
        step(20);
        `CHK(mode, PDN)
        node_dom = 1'b1;
        step(14);
        node_dom = 1'b0;
        wait_mode(RDY, 10);
        tx = 1'b0;
        sel = 1'b1;
        wait_mode(TXO, 40);
        tx = 1'b1;
        sel = 1'b0;
        wait_mode(PDN, 10);
        sel = 1'b1;
        wait_mode(RDY, 10);
        wait_mode(OPR, 40);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        t_power_on();
        t_data();
        t_timeout();
        t_heat();
        t_txe();
        t_contention();
        t_pd();
        do_reset(1'b1);
        wait_mode(OPR, 5);
        complete_run();
    end
    initial begin
        #40000;
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
